// file: src/sfe_map.svh
// Purpose: register offsets, field positions and reset values of the socket register window
// Assumes: included by bare name from design files
// Notes:   definitions only
`ifndef SFE_MAP_SVH
`define SFE_MAP_SVH

// byte offsets inside the socket register window
`define SFE_OFF_EVENT        8'h00
`define SFE_OFF_MASK         8'h04
`define SFE_OFF_PRESENT      8'h08
`define SFE_OFF_FORCE        8'h0C
`define SFE_OFF_CONTROL      8'h10

// force-event register fields
`define SFE_FRC_REINTERROGATE 14
`define SFE_FRC_CAP_HI        13
`define SFE_FRC_CAP_LO        10
`define SFE_FRC_INVALID_REQ   9
`define SFE_FRC_LOST_WRITE    8
`define SFE_FRC_UNRECOGNISED  7
`define SFE_FRC_RESERVED      6
`define SFE_FRC_CARDBUS       5
`define SFE_FRC_SIXTEEN       4
`define SFE_FRC_POWER_EVT     3
`define SFE_FRC_DETECT_B_EVT  2
`define SFE_FRC_DETECT_A_EVT  1
`define SFE_FRC_STATUS_EVT    0

// present-state fields share the force-event positions; supply capability sits higher
`define SFE_PS_SUPPLY_HI      31
`define SFE_PS_SUPPLY_LO      28
`define SFE_PS_SUPPLY_RST     4'h3

// event register width and reset values
`define SFE_EVT_W             4
`define SFE_EVT_RST           4'h0
`define SFE_MASK_RST          4'h0

// socket control fields
`define SFE_CTL_VPP_LO        0
`define SFE_CTL_VCC_LO        4
`define SFE_CTL_STOPCLK       7
`define SFE_CTL_ENABLE        31
`define SFE_CTL_RST           8'h00

`endif

// file: src/sfe_pin_sync.sv
// Purpose: three-stage synchroniser for socket pin levels
// Assumes: inputs are asynchronous to sys_clk_i
// Notes:   a change is accepted only once stages two and three agree;
//          level_o resets to zero, so idle-high pins should be fed inverted
module sfe_pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    // pins and filtered level
    input  wire logic [WIDTH-1:0] pin_i,
    input  wire logic [WIDTH-1:0] rst_val_i,
    output logic      [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [1:0]       fill_q;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
        end else begin
            stage1_q <= pin_i;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // level held at reset value until stages two and three both carry sampled pins,
    // otherwise their zero reset shows up as a false pin change
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fill_q  <= 2'h0;
            level_o <= '0;
        end else begin
            if (fill_q != 2'h3) begin
                fill_q <= fill_q + 2'h1;
            end
            for (int i = 0; i < WIDTH; i++) begin
                if (fill_q != 2'h3) begin
                    level_o[i] <= rst_val_i[i];
                end else if (stage2_q[i] == stage3_q[i]) begin
                    level_o[i] <= stage3_q[i];
                end
            end
        end
    end

endmodule : sfe_pin_sync

// file: src/sfe_pkg.sv
// Purpose: shared types of the socket force-event block
// Assumes: constants live in sfe_map.svh
// Notes:   nothing here is imported; use sfe_pkg::name
package sfe_pkg;

    typedef enum logic [0:0] {
        SFE_IDLE,
        SFE_INTERROGATE
    } sfe_state_t;

    typedef logic [3:0] sfe_nibble_t;

endpackage : sfe_pkg

// file: src/sfe_socket_force.sv
// Contract
// RULE1 - force-event register is a 32-bit word at byte offset 0Ch
// RULE2 - reads return zero in bits 31 down to 15
// RULE3 - bit 6 is reserved: writes ignored, reads zero
// RULE4 - writing one to bit 14 reinterrogates, refreshes present state, enables control
// RULE5 - software needing interrogation after forcing must also write bit 14
// RULE6 - bits 13..10 copy into matching card voltage capability bits
// RULE7 - any forced capability bit set disables socket control until reinterrogation
// RULE8 - bit 9 loads the invalid supply request flag
// RULE9 - bit 8 loads the lost write flag
// RULE10 - bit 7 loads the unrecognised card flag
// RULE11 - bit 5 loads the cardbus detected flag
// RULE12 - bit 4 loads the sixteen bit detected flag
// RULE13 - bit 3 sets power event; powered status unchanged
// RULE14 - bits 2 and 1 set detect events; detect levels unchanged
// RULE15 - bit 0 sets status change event; status level unchanged
// RULE16 - supply capability bits 31..28 keep hardwired values
// RULE17 - force-event register reads zero in all 32 bits
//
// Purpose: socket register window with force-event write logic, behind an APB slave
// Assumes: interrogation engine answers on sys_clk_i; socket pins are asynchronous
// Notes:   zero-wait APB; event bits are sticky, cleared by writing one
`include "sfe_map.svh"

module sfe_socket_force #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_b_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // socket pins
    input  wire logic              detect_a_pin_i,
    input  wire logic              detect_b_pin_i,
    input  wire logic              status_change_pin_i,
    input  wire logic              socket_powered_i,
    // interrogation engine
    output logic                   interrogate_req_o,
    input  wire logic              interrogate_done_i,
    input  wire logic [3:0]        result_volt_cap_i,
    input  wire logic              result_cardbus_i,
    input  wire logic              result_sixteen_i,
    input  wire logic              result_unrecognised_i,
    // socket control outputs
    output logic                   socket_ctrl_enable_o,
    output logic [2:0]             vcc_ctrl_o,
    output logic [2:0]             vpp_ctrl_o,
    output logic                   stop_clock_o,
    // interrupt
    output logic                   irq_o
);

    logic                  rst_meta_q;
    logic                  rst_n_q;

    logic [3:0]            pins_lvl;
    logic                  detect_a_level;
    logic                  detect_b_level;
    logic                  status_change_level;
    logic                  socket_powered_status;
    logic                  detect_a_prev_q;
    logic                  detect_b_prev_q;
    logic                  status_prev_q;
    logic                  powered_prev_q;

    logic                  setup;
    logic                  access;
    logic                  wr_acc;
    logic                  addr_hit;
    logic [31:0]           rd_d;
    logic                  wr_force;
    logic                  wr_event;
    logic                  wr_mask;
    logic                  wr_control;

    sfe_pkg::sfe_nibble_t  volt_cap_q;
    logic                  invalid_supply_request_q;
    logic                  lost_write_flag_q;
    logic                  unrecognised_card_flag_q;
    logic                  cardbus_detected_q;
    logic                  sixteen_bit_detected_q;
    sfe_pkg::sfe_nibble_t  event_q;
    sfe_pkg::sfe_nibble_t  event_set;
    sfe_pkg::sfe_nibble_t  mask_q;
    logic [7:0]            control_q;
    sfe_pkg::sfe_state_t   state_q;
    logic [31:0]           present_state;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // detect pins idle high (no card) and pass inverted, so the zero reset is the idle level
    sfe_pin_sync #(
        .WIDTH (4)
    ) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_q),
        .pin_i     ({socket_powered_i, status_change_pin_i, ~detect_b_pin_i, ~detect_a_pin_i}),
        .rst_val_i (4'h0),
        .level_o   (pins_lvl)
    );

    assign detect_a_level        = ~pins_lvl[0];
    assign detect_b_level        = ~pins_lvl[1];
    assign status_change_level   = pins_lvl[2];
    assign socket_powered_status = pins_lvl[3];

    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            detect_a_prev_q <= 1'b1;
            detect_b_prev_q <= 1'b1;
            status_prev_q   <= 1'b0;
            powered_prev_q  <= 1'b0;
        end else begin
            detect_a_prev_q <= detect_a_level;
            detect_b_prev_q <= detect_b_level;
            status_prev_q   <= status_change_level;
            powered_prev_q  <= socket_powered_status;
        end
    end

    // apb decode
    assign setup  = psel_i && !penable_i;
    assign access = psel_i && penable_i && pready_o;
    assign wr_acc = access && pwrite_i && !pslverr_o;

    always_comb begin
        addr_hit = 1'b1;
        if (paddr_i == ADDR_W'(`SFE_OFF_EVENT)) begin
            rd_d = {28'h0000000, event_q};
        end else if (paddr_i == ADDR_W'(`SFE_OFF_MASK)) begin
            rd_d = {28'h0000000, mask_q};
        end else if (paddr_i == ADDR_W'(`SFE_OFF_PRESENT)) begin
            rd_d = present_state;
        end else if (paddr_i == ADDR_W'(`SFE_OFF_FORCE)) begin // [RULE1]
            rd_d = 32'h00000000; // write-only bits keep no readable state [RULE17] [RULE2] [RULE3]
        end else if (paddr_i == ADDR_W'(`SFE_OFF_CONTROL)) begin
            rd_d = {socket_ctrl_enable_o, 23'h000000, control_q};
        end else begin
            rd_d     = 32'h00000000;
            addr_hit = 1'b0;
        end
    end

    assign wr_force   = wr_acc && (paddr_i == ADDR_W'(`SFE_OFF_FORCE)); // [RULE1]
    assign wr_event   = wr_acc && (paddr_i == ADDR_W'(`SFE_OFF_EVENT));
    assign wr_mask    = wr_acc && (paddr_i == ADDR_W'(`SFE_OFF_MASK));
    assign wr_control = wr_acc && (paddr_i == ADDR_W'(`SFE_OFF_CONTROL));

    // read data and ready are launched in setup so every answer comes from a flop
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup && !addr_hit;
            if (setup && !pwrite_i) begin
                prdata_o <= rd_d;
            end else if (access) begin
                prdata_o <= 32'h00000000;
            end
        end
    end

    // present-state assembly; bit 6 and 27..14 read zero
    always_comb begin
        present_state = 32'h00000000;
        present_state[`SFE_PS_SUPPLY_HI:`SFE_PS_SUPPLY_LO] = `SFE_PS_SUPPLY_RST; // [RULE16]
        present_state[`SFE_FRC_CAP_HI:`SFE_FRC_CAP_LO]     = volt_cap_q;
        present_state[`SFE_FRC_INVALID_REQ]  = invalid_supply_request_q;
        present_state[`SFE_FRC_LOST_WRITE]   = lost_write_flag_q;
        present_state[`SFE_FRC_UNRECOGNISED] = unrecognised_card_flag_q;
        present_state[`SFE_FRC_CARDBUS]      = cardbus_detected_q;
        present_state[`SFE_FRC_SIXTEEN]      = sixteen_bit_detected_q;
        present_state[`SFE_FRC_POWER_EVT]    = socket_powered_status;
        present_state[`SFE_FRC_DETECT_B_EVT] = detect_b_level;
        present_state[`SFE_FRC_DETECT_A_EVT] = detect_a_level;
        present_state[`SFE_FRC_STATUS_EVT]   = status_change_level;
    end

    // interrogation handshake; the engine itself lives outside
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q           <= sfe_pkg::SFE_IDLE;
            interrogate_req_o <= 1'b0;
        end else begin
            case (state_q)
                sfe_pkg::SFE_IDLE: begin
                    if (wr_force && pwdata_i[`SFE_FRC_REINTERROGATE]) begin // [RULE4] [RULE5]
                        state_q           <= sfe_pkg::SFE_INTERROGATE;
                        interrogate_req_o <= 1'b1;
                    end
                end
                sfe_pkg::SFE_INTERROGATE: begin
                    if (interrogate_done_i) begin
                        state_q           <= sfe_pkg::SFE_IDLE;
                        interrogate_req_o <= 1'b0;
                    end
                end
                default: begin
                    state_q           <= sfe_pkg::SFE_IDLE;
                    interrogate_req_o <= 1'b0;
                end
            endcase
        end
    end

    // card type flags: force writes load them, interrogation results refresh them except invalid supply request and lost write
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            volt_cap_q               <= 4'h0;
            invalid_supply_request_q <= 1'b0;
            lost_write_flag_q        <= 1'b0;
            unrecognised_card_flag_q <= 1'b0;
            cardbus_detected_q       <= 1'b0;
            sixteen_bit_detected_q   <= 1'b0;
        end else if (state_q == sfe_pkg::SFE_INTERROGATE && interrogate_done_i) begin
            volt_cap_q               <= result_volt_cap_i; // [RULE4]
            unrecognised_card_flag_q <= result_unrecognised_i;
            cardbus_detected_q       <= result_cardbus_i;
            sixteen_bit_detected_q   <= result_sixteen_i;
        end else if (wr_force) begin
            volt_cap_q               <= pwdata_i[`SFE_FRC_CAP_HI:`SFE_FRC_CAP_LO]; // [RULE6]
            invalid_supply_request_q <= pwdata_i[`SFE_FRC_INVALID_REQ]; // [RULE8]
            lost_write_flag_q        <= pwdata_i[`SFE_FRC_LOST_WRITE]; // [RULE9]
            unrecognised_card_flag_q <= pwdata_i[`SFE_FRC_UNRECOGNISED]; // [RULE10]
            cardbus_detected_q       <= pwdata_i[`SFE_FRC_CARDBUS]; // [RULE11]
            sixteen_bit_detected_q   <= pwdata_i[`SFE_FRC_SIXTEEN]; // [RULE12]
        end
    end

    // socket control gate: forced capability disables, finished interrogation enables
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            socket_ctrl_enable_o <= 1'b1;
        end else if (state_q == sfe_pkg::SFE_INTERROGATE && interrogate_done_i) begin
            socket_ctrl_enable_o <= 1'b1; // [RULE4]
        end else if (wr_force && |pwdata_i[`SFE_FRC_CAP_HI:`SFE_FRC_CAP_LO]) begin
            socket_ctrl_enable_o <= 1'b0; // [RULE7]
        end
    end

    // writes to socket control are dropped while it is disabled
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            control_q <= `SFE_CTL_RST;
        end else if (wr_control && socket_ctrl_enable_o) begin
            control_q <= {pwdata_i[`SFE_CTL_STOPCLK], pwdata_i[`SFE_CTL_VCC_LO +: 3],
                          1'b0, pwdata_i[`SFE_CTL_VPP_LO +: 3]};
        end
    end

    assign vcc_ctrl_o   = control_q[`SFE_CTL_VCC_LO +: 3];
    assign vpp_ctrl_o   = control_q[`SFE_CTL_VPP_LO +: 3];
    assign stop_clock_o = control_q[`SFE_CTL_STOPCLK];

    // event sources: pin edges plus forced events; present-state levels untouched
    always_comb begin
        event_set = 4'h0;
        event_set[`SFE_FRC_POWER_EVT]    = (socket_powered_status != powered_prev_q);
        event_set[`SFE_FRC_DETECT_B_EVT] = (detect_b_level != detect_b_prev_q);
        event_set[`SFE_FRC_DETECT_A_EVT] = (detect_a_level != detect_a_prev_q);
        event_set[`SFE_FRC_STATUS_EVT]   = status_change_level && !status_prev_q;
        if (wr_force) begin
            event_set = event_set | pwdata_i[`SFE_EVT_W-1:0]; // [RULE13] [RULE14] [RULE15]
        end
    end

    // set wins over a same-cycle write-one clear
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            event_q <= `SFE_EVT_RST;
        end else if (wr_event) begin
            event_q <= (event_q & ~pwdata_i[`SFE_EVT_W-1:0]) | event_set;
        end else begin
            event_q <= event_q | event_set;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mask_q <= `SFE_MASK_RST;
        end else if (wr_mask) begin
            mask_q <= pwdata_i[`SFE_EVT_W-1:0];
        end
    end

    // one cycle later than the status bit, so the pin stays a flop output
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(event_q & mask_q);
        end
    end

endmodule : sfe_socket_force

// file: tb/sfe_socket_force_properties.sv
// Purpose: port-level assertions for the socket force-event block
// Assumes: zero-wait APB, one access cycle per transfer
// Notes:   attached by bind from the testbench top file
module sfe_socket_force_properties #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic              sys_clk_i,
    input wire logic              rst_b_i,
    // apb
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0]       pwdata_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    // interrogation and socket control
    input wire logic              interrogate_req_o,
    input wire logic              interrogate_done_i,
    input wire logic              socket_ctrl_enable_o
);
    localparam logic [ADDR_W-1:0] FORCE_ADR = ADDR_W'(8'h0C);
    localparam logic [ADDR_W-1:0] PRES_ADR  = ADDR_W'(8'h08);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_force_wr;
        psel_i && penable_i && pready_o && pwrite_i && paddr_i == FORCE_ADR;
    endsequence
    sequence s_done;
        interrogate_req_o && interrogate_done_i;
    endsequence
    a_ready_one_cycle: assert property (s_setup |=> pready_o ##1 !pready_o)
        else $error("access phase not exactly one cycle");
    a_force_read_zero: assert property (
        s_setup ##0 (!pwrite_i && paddr_i == FORCE_ADR) |=> prdata_o == 32'h0000_0000)
        else $error("force register read not zero");
    a_supply_hardwired: assert property (
        s_setup ##0 (!pwrite_i && paddr_i == PRES_ADR) |=> prdata_o[31:28] == 4'h3)
        else $error("supply capability bits changed");
    a_cap_disables: assert property (
        s_force_wr ##0 (pwdata_i[13:10] != 4'h0 && !(interrogate_req_o && interrogate_done_i))
        |=> !socket_ctrl_enable_o)
        else $error("forced capability left control enabled");
    a_enable_stays_off: assert property (
        !socket_ctrl_enable_o && !interrogate_req_o |=> !socket_ctrl_enable_o)
        else $error("control enabled without interrogation");
    a_trigger_starts: assert property (
        s_force_wr ##0 (pwdata_i[14] && !interrogate_req_o) |=> interrogate_req_o)
        else $error("interrogation not requested");
    a_req_waits: assert property (interrogate_req_o && !interrogate_done_i |=> interrogate_req_o)
        else $error("request dropped before done");
    a_done_enables: assert property (s_done |=> !interrogate_req_o && socket_ctrl_enable_o)
        else $error("interrogation end did not enable control");
endmodule : sfe_socket_force_properties

// file: tb/sfe_socket_force_test.sv
// Purpose: self-checking bench for the socket force-event block
// Assumes: zero-wait APB slave, results sampled on the done cycle
// Notes:   pins settle through a three-flop synchroniser before reads
module sfe_socket_force_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i, rst_b_i, psel_i, penable_i, pwrite_i;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic        pready_o, pslverr_o, req, done, ena, irq, cb, sx, un, sts, stp;
    logic [2:0]  vcc, vpp;
    logic [3:0]  cap;
    int          mismatches, n_checks;
    sfe_socket_force uut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .detect_a_pin_i(1'b1), .detect_b_pin_i(1'b1), .status_change_pin_i(sts),
        .socket_powered_i(1'b0), .interrogate_req_o(req), .interrogate_done_i(done),
        .result_volt_cap_i(cap), .result_cardbus_i(cb), .result_sixteen_i(sx),
        .result_unrecognised_i(un), .socket_ctrl_enable_o(ena), .vcc_ctrl_o(vcc),
        .vpp_ctrl_o(vpp), .stop_clock_o(stp), .irq_o(irq));
    always #20 sys_clk_i = ~sys_clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        // no cycle limit here: only the watchdog ends a stalled transfer
        do begin
            @(posedge sys_clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        #1;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
    endtask : rd_chk
    task automatic t_reset;
        rd_chk(8'h0C, 32'h0000_0000);
        rd_chk(8'h08, 32'h3000_0006);
        rd_chk(8'h00, 32'h0000_0000);
        chk({31'h0, ena}, 32'h1);
    endtask : t_reset
    task automatic t_force_bits;
        wr(8'h0C, 32'hFFFF_BFF0);
        chk({31'h0, ena}, 32'h0);
        rd_chk(8'h0C, 32'h0000_0000);
        rd_chk(8'h08, 32'h3000_3FB6);
        wr(8'h0C, 32'h0000_0000);
        rd_chk(8'h08, 32'h3000_0006);
        chk({31'h0, ena}, 32'h0);
    endtask : t_force_bits
    task automatic t_events;
        wr(8'h0C, 32'h0000_000F);
        rd_chk(8'h00, 32'h0000_000F);
        rd_chk(8'h08, 32'h3000_0006);
        chk({31'h0, irq}, 32'h0);
        wr(8'h04, 32'h0000_000F);
        repeat (2) @(posedge sys_clk_i);
        #1 chk({31'h0, irq}, 32'h1);
        wr(8'h00, 32'h0000_000F);
        repeat (2) @(posedge sys_clk_i);
        #1 chk({31'h0, irq}, 32'h0);
        rd_chk(8'h00, 32'h0000_0000);
    endtask : t_events
    task automatic t_interrogate;
        // control writes are dropped while disabled
        wr(8'h10, 32'h0000_00FF);
        rd_chk(8'h10, 32'h0000_0000);
        // caps forced together with the trigger: disabled until the result lands
        wr(8'h0C, 32'h0000_4400);
        chk({30'h0, req, ena}, 32'h2);
        @(posedge sys_clk_i);
        done <= 1'b1;
        cap <= 4'h5;
        cb <= 1'b1;
        sx <= 1'b1;
        un <= 1'b1;
        @(posedge sys_clk_i);
        done <= 1'b0;
        #1 chk({30'h0, req, ena}, 32'h1);
        rd_chk(8'h08, 32'h3000_14B6);
        wr(8'h10, 32'h0000_00FF);
        rd_chk(8'h10, 32'h8000_00F7);
        chk({25'h0, stp, vcc, vpp}, 32'h0000_007F);
    endtask : t_interrogate
    task automatic t_misc;
        logic [31:0] r;
        logic        e;
        apb(1'b0, 8'h40, 32'h0000_0000, r, e);
        chk({e, r[30:0]}, 32'h8000_0000);
        sts <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        rd_chk(8'h00, 32'h0000_0001);
        chk({31'h0, irq}, 32'h1);
    endtask : t_misc
    task automatic stop_test;
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        #100us;
        mismatches++;
        stop_test();
    end
    initial begin
        {sys_clk_i, rst_b_i, psel_i, penable_i, pwrite_i, done, cb, sx, un, sts} = '0;
        {paddr_i, pwdata_i, cap, mismatches, n_checks} = '0;
        repeat (6) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        // wait out reset sync and pin sync before first transfer
        repeat (10) @(posedge sys_clk_i);
        t_reset();
        t_force_bits();
        t_events();
        t_interrogate();
        t_misc();
        stop_test();
    end
endmodule : sfe_socket_force_test
bind sfe_socket_force sfe_socket_force_properties #(.ADDR_W(ADDR_W)) u_props (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .interrogate_req_o(interrogate_req_o),
    .interrogate_done_i(interrogate_done_i), .socket_ctrl_enable_o(socket_ctrl_enable_o));
